// ---- serdes_cfg.svh ----
// Timing counts, offsets and field positions shared by both ends of the quad serdes link
`ifndef SERDES_CFG_SVH
`define SERDES_CFG_SVH

// ****************************************************************
// Link shape
// ****************************************************************
`define NUM_CH 4
`define CHAR_BITS 10
`define COMMA_PAT 7'h7c
`define ALIGN_POS 5'h6
`define BITS_SLOW 5'h14
`define BITS_FAST 5'ha

// ****************************************************************
// Timing, system clock 100 MHz
// ****************************************************************
`define CLK_PERIOD_NS 10
`define BIT_NS 40
`define BIT_CYC (`BIT_NS / `CLK_PERIOD_NS)
`define TX_LAT_BITS 7
`define SYNC_DLY 3
`define TX_LAT_CYC ((`TX_LAT_BITS * `BIT_CYC) - `SYNC_DLY)
`define REF_HALF_CYC ((`CHAR_BITS * `BIT_CYC) / 2)
`define RX_SAMPLE_PH 2'h2

// ****************************************************************
// Controller register map (byte addresses) and fields
// ****************************************************************
`define REG_CTRL 6'h00
`define REG_TXD_BASE 2'h1
`define REG_RXD_BASE 2'h2
`define REG_STATUS 6'h30
`define REG_MASK 6'h34
`define CTRL_LOOP 0
`define CTRL_ALIGN 1
`define CTRL_RATE 2
`define RXD_COMMA 10
`define STAT_COMMA 0
`define STAT_CHAR 4

`endif

// ---- serdes_dev.sv ----
// Device end: four channels of serializer, clock recovery, deserializer and comma alignment
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
module serdes_dev
	import serdes_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [`NUM_CH-1:0] SERIAL_IN_I,
	output logic [`NUM_CH-1:0] SERIAL_OUT_O,
	serdes_if.dev bus
);

	dev_state_s st;
	dev_state_s next_st;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic ref_rise;
		logic loop_on;
		logic align_on;
		logic rate_fast;
		logic sel;
		logic [4:0] nbits;
		logic [4:0] p;
		char_t sr;
		logic word_end;
		logic comma_seen;
		logic [4:0] slip;
		ref_rise = 1'b0;
		loop_on = 1'b0;
		align_on = 1'b0;
		rate_fast = 1'b0;
		sel = 1'b0;
		nbits = `BITS_SLOW;
		p = 5'h0;
		sr = '0;
		word_end = 1'b0;
		comma_seen = 1'b0;
		slip = 5'h0;
		next_st = st;

		// ****************************************************************
		// Synchronisers
		// ****************************************************************
		// Every pin from the controller crosses two flops first
		next_st.ref_s1 = bus.ref_clock_in;
		next_st.ref_s2 = st.ref_s1;
		next_st.ref_d = st.ref_s2;
		next_st.tx_s1 = bus.tx_char_bus;
		next_st.tx_s2 = st.tx_s1;
		next_st.ctl_s1 = {bus.rx_clk_rate_select, bus.align_en, bus.loopback_en};
		next_st.ctl_s2 = st.ctl_s1;

		ref_rise = st.ref_s2 & ~st.ref_d;
		loop_on = st.ctl_s2[`CTRL_LOOP];
		align_on = st.ctl_s2[`CTRL_ALIGN];
		rate_fast = st.ctl_s2[`CTRL_RATE];
		nbits = rate_fast ? `BITS_FAST : `BITS_SLOW;

		// ****************************************************************
		// Transmit
		// ****************************************************************
		// The bus changes half a reference period from the rise, and data and
		// reference share the same synchroniser depth, so the capture is clean.
		if (ref_rise) begin
			next_st.tx_hold = st.tx_s2;
			next_st.lat = 6'(`TX_LAT_CYC);
		end else if (st.lat != 6'h0) begin
			next_st.lat = st.lat - 6'h1;
		end

		if (st.bitc == 2'(`BIT_CYC - 1)) begin
			next_st.bitc = 2'h0;
		end else begin
			next_st.bitc = st.bitc + 2'h1;
		end

		// Loading on the latency count keeps one character per reference period;
		// the previous character has just shifted out when the next one loads.
		if (st.lat == 6'h1) begin
			next_st.tx_sh = st.tx_hold;
			next_st.bitc = 2'h0;
		end else if (st.bitc == 2'(`BIT_CYC - 1)) begin
			for (int i = 0; i < `NUM_CH; i++) begin
				next_st.tx_sh[i] = {1'b0, st.tx_sh[i][`CHAR_BITS-1:1]};
			end
		end

		// ****************************************************************
		// Receive
		// ****************************************************************
		for (int i = 0; i < `NUM_CH; i++) begin
			next_st.si_s1[i] = SERIAL_IN_I[i];
			next_st.si_s2[i] = st.si_s1[i];
			sel = loop_on ? st.tx_sh[i][0] : st.si_s2[i];
			next_st.si_p[i] = sel;

			// ****************************************************************
			// Phase tracking
			// ****************************************************************
			// Phase restarts on each transition, so the sample sits mid bit;
			// with no transitions the phase free-runs and clocks keep going.
			if (sel != st.si_p[i]) begin
				next_st.ph[i] = 2'h1;
			end else begin
				next_st.ph[i] = st.ph[i] + 2'h1;
			end

			if (st.ph[i] == `RX_SAMPLE_PH) begin
				sr = {sel, st.rsr[i][`CHAR_BITS-1:1]};
				next_st.rsr[i] = sr;
				if (st.hold[i] != 5'h0) begin
					// Position held: the current clock level is stretched
					next_st.hold[i] = st.hold[i] - 5'h1;
				end else begin
					if (st.pos[i] >= nbits - 5'h1) begin
						next_st.pos[i] = 5'h0;
					end else begin
						next_st.pos[i] = st.pos[i] + 5'h1;
					end

					// ****************************************************************
					// Word capture and comma alignment
					// ****************************************************************
					// Bits enter at the top, so the first received bit ends at bit 0
					word_end = (st.pos[i] == 5'h9) || (st.pos[i] == 5'h13);
					comma_seen = align_on && (sr[`CHAR_BITS-1:3] == `COMMA_PAT);
					slip = (st.pos[i] >= `ALIGN_POS) ? st.pos[i] - `ALIGN_POS : st.pos[i] + nbits - `ALIGN_POS;
					if (word_end) begin
						next_st.rx_char[i] = sr;
						next_st.flag[i] = (sr[6:0] == `COMMA_PAT);
					end
					// Aligned means last comma bit at position 6 of a word whose
					// position count sits in the first half of the slow period.
					// Commas seen while a stretch runs are ignored; the next one is caught
					if (comma_seen && slip != 5'h0) begin
						next_st.hold[i] = slip;
					end
				end
			end

			// ****************************************************************
			// Recovered clocks
			// ****************************************************************
			// Data changes at position 0 or 10; clocks rise five bits later
			// Single-clock mode holds the first clock low so the controller ignores it
			p = next_st.pos[i];
			if (rate_fast) begin
				next_st.clk2[i] = (p >= 5'h5) && (p < 5'ha);
				next_st.clk1[i] = 1'b0;
			end else begin
				next_st.clk2[i] = (p >= 5'hf) || (p < 5'h5);
				next_st.clk1[i] = ~next_st.clk2[i];
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Clocks are low in reset; the second clock goes high the cycle after, as position 0 lies in its high window in slow mode
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < `NUM_CH; i++) begin
			// Straight from a flop, so the line carries no glitches
			SERIAL_OUT_O[i] = st.tx_sh[i][0];
		end
	end

	assign bus.rx_char_bus = st.rx_char;
	assign bus.rx_clk_first = st.clk1;
	assign bus.rx_clk_second = st.clk2;
	assign bus.comma_found_flag = st.flag;

endmodule // serdes_dev

// ---- serdes_host.sv ----
// Controller end: reference clock, transmit characters, receive capture and Avalon-MM registers
module serdes_host
	import serdes_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [5:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	output logic IRQ_O,
	serdes_if.host bus
);

	host_state_s st;
	host_state_s next_st;
	logic req;

	assign req = AVS_READ_I | AVS_WRITE_I;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic cap;
		logic [7:0] set_bits;
		logic [1:0] idx;
		cap = 1'b0;
		set_bits = 8'h0;
		idx = AVS_ADDRESS_I[3:2];
		next_st = st;

		// Reference clock from a divider; bus changes on its fall so it is
		// stable around every rise.
		if (st.div == 5'(`REF_HALF_CYC - 1)) begin
			next_st.div = 5'h0;
			next_st.ref_clk = ~st.ref_clk;
			if (st.ref_clk) begin
				next_st.txb = st.txd;
			end
		end else begin
			next_st.div = st.div + 5'h1;
		end

		// Receive pins cross two flops before use
		next_st.c1_s1 = bus.rx_clk_first;
		next_st.c1_s2 = st.c1_s1;
		next_st.c1_p = st.c1_s2;
		next_st.c2_s1 = bus.rx_clk_second;
		next_st.c2_s2 = st.c2_s1;
		next_st.c2_p = st.c2_s2;
		next_st.d_s1 = bus.rx_char_bus;
		next_st.d_s2 = st.d_s1;
		next_st.f_s1 = bus.comma_found_flag;
		next_st.f_s2 = st.f_s1;
		for (int i = 0; i < `NUM_CH; i++) begin
			// In half-rate mode the first clock carries the other characters
			cap = (st.c2_s2[i] & ~st.c2_p[i]) | (st.c1_s2[i] & ~st.c1_p[i] & ~st.ctl[`CTRL_RATE]);
			if (cap) begin
				next_st.rxd[i] = {st.f_s2[i], st.d_s2[i]};
				set_bits[`STAT_CHAR + i] = 1'b1;
				set_bits[`STAT_COMMA + i] = st.f_s2[i];
			end
		end

		// ****************************************************************
		// Avalon-MM slave: one wait state, action on the edge it ends
		// ****************************************************************
		next_st.ack = req & ~st.ack;
		next_st.rdata = 32'h0;
		if (req && !st.ack) begin
			if (AVS_ADDRESS_I == `REG_CTRL) begin
				next_st.rdata = {29'h0, st.ctl};
			end else if (AVS_ADDRESS_I[5:4] == `REG_TXD_BASE) begin
				next_st.rdata = {22'h0, st.txd[idx]};
			end else if (AVS_ADDRESS_I[5:4] == `REG_RXD_BASE) begin
				next_st.rdata = {21'h0, st.rxd[idx]};
			end else if (AVS_ADDRESS_I == `REG_STATUS) begin
				next_st.rdata = {24'h0, st.status};
			end else if (AVS_ADDRESS_I == `REG_MASK) begin
				next_st.rdata = {24'h0, st.mask};
			end
		end

		next_st.status = st.status;
		if (AVS_WRITE_I && st.ack) begin
			if (AVS_ADDRESS_I == `REG_CTRL) begin
				next_st.ctl = AVS_WRITEDATA_I[2:0];
			end else if (AVS_ADDRESS_I[5:4] == `REG_TXD_BASE) begin
				next_st.txd[idx] = AVS_WRITEDATA_I[`CHAR_BITS-1:0];
			end else if (AVS_ADDRESS_I == `REG_STATUS) begin
				next_st.status = st.status & ~AVS_WRITEDATA_I[7:0];
			end else if (AVS_ADDRESS_I == `REG_MASK) begin
				next_st.mask = AVS_WRITEDATA_I[7:0];
			end
		end
		// A new event in the clearing cycle survives
		next_st.status = next_st.status | set_bits;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign AVS_WAITREQUEST_O = req & ~st.ack;
	assign AVS_READDATA_O = st.rdata;
	assign IRQ_O = |(st.status & st.mask);
	assign bus.ref_clock_in = st.ref_clk;
	assign bus.tx_char_bus = st.txb;
	assign bus.loopback_en = st.ctl[`CTRL_LOOP];
	assign bus.align_en = st.ctl[`CTRL_ALIGN];
	assign bus.rx_clk_rate_select = st.ctl[`CTRL_RATE];

endmodule // serdes_host

// ---- serdes_if.sv ----
// Parallel-side link between the quad serdes device and its protocol controller
interface serdes_if;
	import serdes_pkg::*;
	logic ref_clock_in;
	char_t [`NUM_CH-1:0] tx_char_bus;
	logic loopback_en;
	logic align_en;
	logic rx_clk_rate_select;
	char_t [`NUM_CH-1:0] rx_char_bus;
	lane_t rx_clk_first;
	lane_t rx_clk_second;
	lane_t comma_found_flag;

	modport dev (
		input ref_clock_in, tx_char_bus, loopback_en, align_en, rx_clk_rate_select,
		output rx_char_bus, rx_clk_first, rx_clk_second, comma_found_flag
	);
	modport host (
		output ref_clock_in, tx_char_bus, loopback_en, align_en, rx_clk_rate_select,
		input rx_char_bus, rx_clk_first, rx_clk_second, comma_found_flag
	);
endinterface // serdes_if

// ---- serdes_link_properties.sv ----
// Concurrent checks on the serdes link signals; per-lane checks on lane 0, the single-mode first clock on all four
`include "serdes_cfg.svh"
module serdes_link_checker
	import serdes_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic ref_clock_in,
	input wire char_t [`NUM_CH-1:0] tx_char_bus,
	input wire logic rx_clk_rate_select,
	input wire char_t [`NUM_CH-1:0] rx_char_bus,
	input wire lane_t rx_clk_first,
	input wire lane_t rx_clk_second,
	input wire lane_t comma_found_flag
);
	// ****
	// Clock spacing and properties
	// ****
	logic [7:0] gap;
	logic run;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// A rate switch may give one odd period, so spacing is not judged again until a second-clock rise at least 8 cycles after it
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			gap <= 8'h00;
			run <= 1'b0;
		end else begin
			gap <= $rose(rx_clk_second[0]) ? 8'h00 : gap + {7'h00, gap != 8'hff};
			run <= rx_clk_rate_select == $past(rx_clk_rate_select, 8) && (run || $rose(rx_clk_second[0]));
		end
	end
	sequence rate_low_s;
		!rx_clk_rate_select [*8] ##0 run;
	endsequence
	sequence flag_up_s;
		$rose(comma_found_flag[0]) ##0 rx_clk_rate_select;
	endsequence
	ref_period_a: assert property ($rose(ref_clock_in) |-> ##20 $fell(ref_clock_in) ##20 $rose(ref_clock_in))
		else $error("reference period wrong");
	tx_hold_a: assert property ($changed(tx_char_bus) |-> $fell(ref_clock_in))
		else $error("tx bus moved near reference rise");
	single_clock_a: assert property (rx_clk_rate_select [*8] |-> rx_clk_first == 4'h0)
		else $error("first clock runs in single mode");
	twin_clock_a: assert property (rate_low_s |-> rx_clk_first[0] != rx_clk_second[0])
		else $error("clocks not complementary");
	no_sliver_a: assert property ($rose(rx_clk_second[0]) && run |-> gap >= 8'h27)
		else $error("clock period shortened");
	clock_alive_a: assert property (run |-> gap < 8'hc8)
		else $error("recovered clock stopped");
	flag_comma_a: assert property (comma_found_flag[0] |-> rx_char_bus[0][6:0] == `COMMA_PAT)
		else $error("flag without aligned comma");
	flag_width_a: assert property ($fell(comma_found_flag[0]) |-> $past(comma_found_flag[0], 40))
		else $error("flag shorter than a character");
	flag_clock_a: assert property (flag_up_s |-> ##[19:21] $rose(rx_clk_second[0]))
		else $error("flag not timed to second clock");
	char_hold_a: assert property ($rose(rx_clk_second[0]) |-> $stable(rx_char_bus[0]) [*8])
		else $error("rx char moves at second clock");
endmodule // serdes_link_checker

// ---- serdes_pkg.sv ----
// Types shared by the device end and the controller end of the quad serdes link
package serdes_pkg;
`include "serdes_cfg.svh"

typedef logic [`CHAR_BITS-1:0] char_t;
typedef logic [`NUM_CH-1:0] lane_t;

typedef struct packed {
	logic ref_s1;
	logic ref_s2;
	logic ref_d;
	logic [2:0] ctl_s1;
	logic [2:0] ctl_s2;
	char_t [`NUM_CH-1:0] tx_s1;
	char_t [`NUM_CH-1:0] tx_s2;
	char_t [`NUM_CH-1:0] tx_hold;
	char_t [`NUM_CH-1:0] tx_sh;
	logic [5:0] lat;
	logic [1:0] bitc;
	lane_t si_s1;
	lane_t si_s2;
	lane_t si_p;
	logic [`NUM_CH-1:0][1:0] ph;
	char_t [`NUM_CH-1:0] rsr;
	logic [`NUM_CH-1:0][4:0] pos;
	logic [`NUM_CH-1:0][4:0] hold;
	char_t [`NUM_CH-1:0] rx_char;
	lane_t flag;
	lane_t clk1;
	lane_t clk2;
} dev_state_s;

typedef struct packed {
	logic [4:0] div;
	logic ref_clk;
	char_t [`NUM_CH-1:0] txb;
	char_t [`NUM_CH-1:0] txd;
	logic [2:0] ctl;
	lane_t c1_s1;
	lane_t c1_s2;
	lane_t c1_p;
	lane_t c2_s1;
	lane_t c2_s2;
	lane_t c2_p;
	char_t [`NUM_CH-1:0] d_s1;
	char_t [`NUM_CH-1:0] d_s2;
	lane_t f_s1;
	lane_t f_s2;
	logic [`NUM_CH-1:0][10:0] rxd;
	logic [7:0] status;
	logic [7:0] mask;
	logic ack;
	logic [31:0] rdata;
} host_state_s;

endpackage

// ---- tb.sv ----
// Bench joining the device and controller ends of the serdes link
`include "serdes_cfg.svh"
module tb
	import serdes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, rd, wr, wait_req, irq;
	logic [5:0] adr;
	logic [31:0] wdata, rdata, q, seed = 32'h473c, line_seed = 32'h473c;
	logic [9:0] c;
	logic [1:0] bit_ph;
	lane_t ser_in, ser_out;
	logic bq[$];
	int fails = 0, checked = 0;
	time t0;
	serdes_if sif();
	serdes_dev serdes_dev_inst (.CLK_I(clk), .RST_N_I(rst_n), .SERIAL_IN_I(ser_in), .SERIAL_OUT_O(ser_out), .bus(sif.dev));
	serdes_host serdes_host_inst (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
		.IRQ_O(irq), .bus(sif.host));
	serdes_link_checker serdes_link_checker_inst (.CLK_I(clk), .RST_N_I(rst_n), .ref_clock_in(sif.ref_clock_in),
		.tx_char_bus(sif.tx_char_bus), .rx_clk_rate_select(sif.rx_clk_rate_select),
		.rx_char_bus(sif.rx_char_bus), .rx_clk_first(sif.rx_clk_first), .rx_clk_second(sif.rx_clk_second),
		.comma_found_flag(sif.comma_found_flag));
	// ****
	// Helpers
	// ****
	always #5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Unlocked far line: a new random bit on every lane each bit time
	always @(posedge clk) begin
		bit_ph <= bit_ph + 2'h1;
		if (bit_ph == 2'h0) begin
			line_seed <= xs(line_seed);
			ser_in <= line_seed[3:0];
		end
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do begin
			@(posedge clk);
		end while (wait_req !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic test_done();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// The run needs some 5000 cycles; far beyond that means a hang
	initial begin
		#200000;
		fails++;
		test_done();
	end
	// ****
	// Scenarios
	// ****
	initial begin
		{rd, wr, adr, wdata, ser_in, bit_ph} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		bus(`REG_STATUS, 1'b0, 32'h0);
		check(q, 32'h0);
		bus(6'h3c, 1'b1, 32'hffffffff);
		bus(6'h3c, 1'b0, 32'h0);
		check(q, 32'h0);
		for (int ch = 0; ch < 4; ch++) begin
			seed = xs(seed);
			c = seed[9:0];
			bus({`REG_TXD_BASE, 2'(ch), 2'h0}, 1'b1, {22'h0, c});
			repeat (3) @(posedge sif.ref_clock_in);
			for (int k = 0; k < 10; k++)
				bq.push_back(c[k]);
			// Middle of bit 0, which leaves 7 bit times after the reference rise
			repeat (30) @(negedge clk);
			while (bq.size() > 0) begin
				check(ser_out[ch], bq.pop_front());
				repeat (4) @(negedge clk);
			end
		end
		for (int r = 0; r < 2; r++) begin
			bus(`REG_CTRL, 1'b1, 32'(r) << `CTRL_RATE);
			repeat (300) @(posedge clk);
			for (int ch = 0; ch < 4; ch++) begin
				@(posedge sif.rx_clk_second[ch]);
				t0 = $time;
				@(posedge sif.rx_clk_second[ch]);
				check(32'(($time - t0) / 10), 32'((r ? `BITS_FAST : `BITS_SLOW) * `BIT_CYC));
				@(negedge sif.rx_clk_second[ch]);
				@(negedge clk);
				check(sif.rx_clk_first[ch], 32'(r == 0));
			end
		end
		// Loopback with alignment, then a shifted comma with alignment off, then on again
		c = 10'h17c;
		for (int k = 0; k < 3; k++) begin
			bus(`REG_CTRL, 1'b1, k == 1 ? 32'h5 : 32'h7);
			bus({`REG_TXD_BASE, 4'h0}, 1'b1, k == 0 ? 32'(c) : 32'({c[6:0], c[9:7]}));
			repeat (800) @(posedge clk);
			bus({`REG_RXD_BASE, 4'h0}, 1'b0, 32'h0);
			check(q, k == 1 ? 32'({c[6:0], c[9:7]}) : 32'({1'b1, c}));
		end
		bus(`REG_STATUS, 1'b0, 32'h0);
		check(q & 32'h11, 32'h11);
		bus(`REG_MASK, 1'b1, 32'h1);
		repeat (2) @(posedge clk);
		check(irq, 32'h1);
		bus(`REG_MASK, 1'b1, 32'h0);
		repeat (2) @(posedge clk);
		check(irq, 32'h0);
		test_done();
	end
endmodule // tb
